/* File: logic/pcw_defines.svh */
// constants for the amplifier control-word decoder
// Operation
// - word is all zeros after power-up
// - each frame pushes old word down chain
// - parallel mode: gain pins, derived compensation
// - bits 2:0 choose fixed or external gain
// - fixed gains close internal, open external switch
// - code 111b opens internal, closes external
// - bits 5:3 give five compensation levels
// - serial compensation independent of gain
// - route bits 7:6, polarity bit 8
// - route 00b: differential, polarity swaps
// - route 01b: both inputs on one pin
// - route 1xb: pin divided, other to supply
// - bit 9 set means shutdown
// - parallel compensation table from gain code
// - shift register loads holding on select rise
// - shift register end drives serial output
// - parallel mode: gain, shutdown from pins
`ifndef PCW_DEFINES_SVH
`define PCW_DEFINES_SVH
`define PCW_WORD_W 16
`define PCW_RESET_WORD 16'h0000
`define PCW_GAIN_LSB 0
`define PCW_COMP_LSB 3
`define PCW_ROUTE_LSB 6
`define PCW_POL_BIT 8
`define PCW_POWER_DOWN_BIT 9
`define PCW_GAIN_EXT 3'h7
`define PCW_COMP_HIGH 3'h4
`define PCW_SYNC_W 8
`define PCW_SYNC_INIT 8'h03
`define PCW_SYNC_SCK 0
`define PCW_SYNC_CSN 1
`define PCW_SYNC_SDI 2
`define PCW_SYNC_PAR 3
`define PCW_SYNC_PDN 4
`define PCW_SYNC_GAIN 5
`endif

/* File: logic/pcw_pkg.sv */
// types of the amplifier control-word decoder
package pcw_pkg;
  typedef enum logic [1:0] {
    PCW_IDLE = 2'h1,
    PCW_FRAME = 2'h2
  } pcw_state_t;
  typedef enum logic [1:0] {
    PCW_ROUTE_DIFF = 2'h0,
    PCW_ROUTE_SHORT = 2'h1,
    PCW_ROUTE_POS_DIV = 2'h2,
    PCW_ROUTE_NEG_DIV = 2'h3
  } pcw_route_t;
endpackage

/* File: logic/pcw_sync.sv */
// two-flop synchroniser bank for the pin inputs
`timescale 1ns/1ns
`include "pcw_defines.svh"
module pcw_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // pins and synchronised copies
  input wire logic [`PCW_SYNC_W-1:0] async_in,
  output logic [`PCW_SYNC_W-1:0] sync_out
);
  logic [`PCW_SYNC_W-1:0] stage1;
  logic [`PCW_SYNC_W-1:0] next_stage1;
  logic [`PCW_SYNC_W-1:0] next_sync_out;
  localparam logic [`PCW_SYNC_W-1:0] INIT = `PCW_SYNC_INIT;

  genvar i;
  generate
    for (i = 0; i < `PCW_SYNC_W; i++) begin : g_bit
      // reset value keeps select and clock idle high, so no false frame
      always_comb begin
        next_stage1[i] = reset ? INIT[i] : async_in[i];
        next_sync_out[i] = reset ? INIT[i] : stage1[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    stage1 <= next_stage1;
    sync_out <= next_sync_out;
  end
endmodule

/* File: logic/pcw_top.sv */
// control-word shift, hold and switch decode of the programmable amplifier
`timescale 1ns/1ns
`include "pcw_defines.svh"
module pcw_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // serial link pins
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out,
  // parallel mode pins
  input wire logic parallel_mode,
  input wire logic [2:0] gain_pins,
  input wire logic power_down_pin,
  // gain and compensation
  output logic [2:0] gain_code,
  output logic [2:0] comp_level,
  output logic internal_gain_switch,
  output logic external_feedback_switch,
  // input switch network
  output logic inp_to_pos_pin,
  output logic inp_to_neg_pin,
  output logic inn_to_pos_pin,
  output logic inn_to_neg_pin,
  output logic inp_to_vneg,
  output logic inn_to_vneg,
  output logic div50_enable,
  // power state
  output logic power_down
);
  logic [`PCW_SYNC_W-1:0] pins_s;
  logic sck_s;
  logic csn_s;
  logic sdi_s;
  logic par_s;
  logic pdn_s;
  logic [2:0] gain_s;
  logic sck_prev;
  logic next_sck_prev;
  logic sck_rise;
  logic cs_rise;
  pcw_pkg::pcw_state_t state;
  pcw_pkg::pcw_state_t next_state;
  logic [`PCW_WORD_W-1:0] shift_word;
  logic [`PCW_WORD_W-1:0] next_shift_word;
  logic [`PCW_WORD_W-1:0] amplifier_control_word;
  logic [`PCW_WORD_W-1:0] next_control_word;
  logic next_serial_out;
  logic [2:0] next_gain_code;
  logic [2:0] next_comp_level;
  logic next_int_sw;
  logic next_ext_sw;
  logic [6:0] next_route_sw;
  logic next_power_down;
  pcw_pkg::pcw_route_t route;
  logic polarity_invert;

  pcw_sync u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in({gain_pins, power_down_pin, parallel_mode, serial_in, chip_select_n,
      serial_clk}),
    .sync_out(pins_s)
  );

  assign sck_s = pins_s[`PCW_SYNC_SCK];
  assign csn_s = pins_s[`PCW_SYNC_CSN];
  assign sdi_s = pins_s[`PCW_SYNC_SDI];
  assign par_s = pins_s[`PCW_SYNC_PAR];
  assign pdn_s = pins_s[`PCW_SYNC_PDN];
  assign gain_s = pins_s[`PCW_SYNC_GAIN +: 3];

  // five levels: the low bits do not matter once the top bit is set
  function automatic logic [2:0] norm_comp(input logic [2:0] c);
    norm_comp = c[2] ? `PCW_COMP_HIGH : c;
  endfunction

  // compensation picked from the gain code when pins drive the gain
  function automatic logic [2:0] derive_comp(input logic [2:0] g);
    case (g)
      3'h0, 3'h1: derive_comp = 3'h0;
      3'h2: derive_comp = 3'h1;
      3'h3, 3'h4: derive_comp = 3'h2;
      3'h5, 3'h6: derive_comp = 3'h3;
      default: derive_comp = `PCW_COMP_HIGH;
    endcase
  endfunction

  assign sck_rise = sck_s && !sck_prev;
  assign cs_rise = (state == pcw_pkg::PCW_FRAME) && csn_s;

  // frame tracking and shifting
  always_comb begin
    next_sck_prev = sck_s;
    next_state = state;
    next_shift_word = shift_word;
    next_control_word = amplifier_control_word;
    case (state)
      pcw_pkg::PCW_IDLE: begin
        if (!csn_s) begin
          next_state = pcw_pkg::PCW_FRAME;
        end
      end
      pcw_pkg::PCW_FRAME: begin
        if (csn_s) begin
          next_state = pcw_pkg::PCW_IDLE;
          next_control_word = shift_word;
        end else if (sck_rise) begin
          next_shift_word = {shift_word[`PCW_WORD_W-2:0], sdi_s};
        end
      end
      default: begin
        next_state = pcw_pkg::PCW_IDLE;
      end
    endcase
    // the oldest bit leaves toward the next device in the chain
    next_serial_out = shift_word[`PCW_WORD_W-1];
    if (reset) begin
      next_state = pcw_pkg::PCW_IDLE;
      next_shift_word = `PCW_RESET_WORD;
      next_control_word = `PCW_RESET_WORD;
      next_serial_out = 1'b0;
      next_sck_prev = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    sck_prev <= next_sck_prev;
    state <= next_state;
    shift_word <= next_shift_word;
    amplifier_control_word <= next_control_word;
    serial_out <= next_serial_out;
  end

  // switch decode, read from the holding word (gain and shutdown from the pins in parallel mode) so shifting never glitches it
  always_comb begin
    route = pcw_pkg::pcw_route_t'(amplifier_control_word[`PCW_ROUTE_LSB +: 2]);
    polarity_invert = amplifier_control_word[`PCW_POL_BIT];
    if (par_s) begin
      next_gain_code = gain_s;
      next_comp_level = derive_comp(gain_s);
      next_power_down = pdn_s;
    end else begin
      next_gain_code = amplifier_control_word[`PCW_GAIN_LSB +: 3];
      next_comp_level = norm_comp(amplifier_control_word[`PCW_COMP_LSB +: 3]);
      next_power_down = amplifier_control_word[`PCW_POWER_DOWN_BIT];
    end
    next_int_sw = next_gain_code != `PCW_GAIN_EXT;
    next_ext_sw = next_gain_code == `PCW_GAIN_EXT;
    // order: inp_pos, inp_neg, inn_pos, inn_neg, inp_vneg, inn_vneg, div50
    case (route)
      pcw_pkg::PCW_ROUTE_DIFF: next_route_sw = polarity_invert ? 7'h30 : 7'h48;
      pcw_pkg::PCW_ROUTE_SHORT: next_route_sw = polarity_invert ? 7'h28 : 7'h50;
      pcw_pkg::PCW_ROUTE_POS_DIV: next_route_sw = polarity_invert ? 7'h15 : 7'h43;
      pcw_pkg::PCW_ROUTE_NEG_DIV: next_route_sw = polarity_invert ? 7'h0D : 7'h23;
      default: next_route_sw = 7'h48;
    endcase
    if (reset) begin
      next_gain_code = 3'h0;
      next_comp_level = 3'h0;
      next_power_down = 1'b0;
      next_int_sw = 1'b1;
      next_ext_sw = 1'b0;
      next_route_sw = 7'h48;
    end
  end

  always_ff @(posedge clk_sys) begin
    gain_code <= next_gain_code;
    comp_level <= next_comp_level;
    power_down <= next_power_down;
    internal_gain_switch <= next_int_sw;
    external_feedback_switch <= next_ext_sw;
    {inp_to_pos_pin, inp_to_neg_pin, inn_to_pos_pin, inn_to_neg_pin, inp_to_vneg,
      inn_to_vneg, div50_enable} <= next_route_sw;
  end

  reset_word_a: assert property (@(posedge clk_sys) reset |=>
    amplifier_control_word == `PCW_RESET_WORD ##1 gain_code == 3'h0 && !power_down)
    else $error("control word not cleared by reset");

  chain_shift_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state == pcw_pkg::PCW_FRAME && !csn_s && sck_rise) |=>
    shift_word == {$past(shift_word[`PCW_WORD_W-2:0]), $past(sdi_s)})
    else $error("shift register did not take serial bit");

  par_gain_a: assert property (@(posedge clk_sys) disable iff (reset)
    par_s |=> gain_code == $past(gain_s) && comp_level == derive_comp($past(gain_s)))
    else $error("parallel gain or compensation wrong");

  gain_switch_a: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 internal_gain_switch == (gain_code != `PCW_GAIN_EXT) &&
    external_feedback_switch == !internal_gain_switch)
    else $error("gain switches disagree with gain code");

  serial_comp_a: assert property (@(posedge clk_sys) disable iff (reset)
    !par_s |=> comp_level == norm_comp($past(amplifier_control_word[`PCW_COMP_LSB +: 3])))
    else $error("serial compensation not from stored field");

  route_diff_a: assert property (@(posedge clk_sys) disable iff (reset)
    amplifier_control_word[`PCW_POL_BIT:`PCW_ROUTE_LSB] == 3'h0 |=>
    inp_to_pos_pin && inn_to_neg_pin && !div50_enable && !inp_to_vneg)
    else $error("normal differential routing wrong");

  route_div_a: assert property (@(posedge clk_sys) disable iff (reset)
    amplifier_control_word[`PCW_ROUTE_LSB + 1] |=>
    div50_enable && (inp_to_vneg != inn_to_vneg))
    else $error("divided routing wrong");

  // the input left on a pin must be the one not tied to the supply
  div_polarity_a: assert property (@(posedge clk_sys) disable iff (reset)
    amplifier_control_word[`PCW_ROUTE_LSB + 1] |=>
    inp_to_vneg == $past(amplifier_control_word[`PCW_POL_BIT]) &&
    (inp_to_pos_pin || inp_to_neg_pin) == !inp_to_vneg)
    else $error("divided routing polarity wrong");

  shutdown_a: assert property (@(posedge clk_sys) disable iff (reset)
    !par_s |=> power_down == $past(amplifier_control_word[`PCW_POWER_DOWN_BIT]))
    else $error("shutdown bit not applied");

  load_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    cs_rise |=> amplifier_control_word == $past(shift_word))
    else $error("holding word not loaded on select rise");

  hold_stable_a: assert property (@(posedge clk_sys) disable iff (reset)
    !cs_rise |=> $stable(amplifier_control_word))
    else $error("holding word changed outside select rise");

  serial_out_a: assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> serial_out == $past(shift_word[`PCW_WORD_W-1]))
    else $error("serial output not shift register end");
endmodule

/* File: sim/pcw_host.sv */
// host-side serial shift driver for the control-word link
`timescale 1ns/1ns
module pcw_host (
  // clock
  input wire logic clk_sys,
  // link pins
  output logic serial_clk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_out
);
  initial begin
    serial_clk = 1'b1;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // drives land just after an edge so no race with the sampling flops
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  // one whole frame, msb first; got is what left the far end of the shifter
  task automatic send_word(input logic [15:0] w, output logic [15:0] got);
    chip_select_n = 1'b0; // link clock held high across select edges
    tick(4);
    for (int i = 15; i >= 0; i--) begin
      serial_clk = 1'b0;
      serial_in = w[i];
      tick(4);
      got[i] = serial_out; // old word leaves before each rising edge
      serial_clk = 1'b1;
      tick(4);
    end
    chip_select_n = 1'b1;
    // data line not meaningful outside a frame, so leave it on the inverse
    serial_in = ~w[0];
    tick(4);
  endtask
endmodule

/* File: sim/pcw_top_tb.sv */
// self-checking bench for the control-word decoder
`timescale 1ns/1ns
module pcw_top_tb;
  logic clk_sys, reset, parallel_mode, power_down_pin, serial_clk, chip_select_n;
  logic serial_in, serial_out, internal_gain_switch, external_feedback_switch;
  logic inp_to_pos_pin, inp_to_neg_pin, inn_to_pos_pin, inn_to_neg_pin;
  logic inp_to_vneg, inn_to_vneg, div50_enable, power_down;
  logic [2:0] gain_pins, gain_code, comp_level;
  logic [15:0] seen, prev, got, w;
  int mismatches, cmp_count;
  localparam logic [15:0] CORNER [4] = '{16'h0013, 16'h001E, 16'h0001, 16'hFFFF};
  assign seen = {gain_code, comp_level, internal_gain_switch, external_feedback_switch,
    inp_to_pos_pin, inp_to_neg_pin, inn_to_pos_pin, inn_to_neg_pin, inp_to_vneg,
    inn_to_vneg, div50_enable, power_down};
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  pcw_host host_u (.clk_sys(clk_sys), .serial_clk(serial_clk),
    .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out));
  pcw_top dut_u (.clk_sys(clk_sys), .reset(reset), .serial_clk(serial_clk),
    .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out),
    .parallel_mode(parallel_mode), .gain_pins(gain_pins), .power_down_pin(power_down_pin),
    .gain_code(gain_code), .comp_level(comp_level),
    .internal_gain_switch(internal_gain_switch),
    .external_feedback_switch(external_feedback_switch), .inp_to_pos_pin(inp_to_pos_pin),
    .inp_to_neg_pin(inp_to_neg_pin), .inn_to_pos_pin(inn_to_pos_pin),
    .inn_to_neg_pin(inn_to_neg_pin), .inp_to_vneg(inp_to_vneg), .inn_to_vneg(inn_to_vneg),
    .div50_enable(div50_enable), .power_down(power_down));
  // packed order matches seen
  function automatic logic [15:0] exp_vec(input logic [2:0] g, input logic [2:0] c,
      input logic [2:0] rp, input logic pd);
    logic [6:0] r;
    case (rp)
      3'h0: r = 7'h48;
      3'h4: r = 7'h30;
      3'h1: r = 7'h50;
      3'h5: r = 7'h28;
      3'h2: r = 7'h43;
      3'h6: r = 7'h15;
      3'h3: r = 7'h23;
      default: r = 7'h0D;
    endcase
    return {g, c, g != 3'h7, g == 3'h7, r, pd};
  endfunction
  function automatic logic [2:0] par_comp(input logic [2:0] g);
    case (g)
      3'h0, 3'h1: return 3'h0;
      3'h2: return 3'h1;
      3'h3, 3'h4: return 3'h2;
      3'h5, 3'h6: return 3'h3;
      default: return 3'h4;
    endcase
  endfunction
  // keeps random words inside the stable compensation range for their gain
  function automatic logic [2:0] host_comp(input logic [2:0] g, input logic [2:0] c);
    if (c[2]) return c;
    case (g)
      3'h0, 3'h1: return 3'h0;
      3'h2: return (c > 3'h1) ? 3'h1 : c;
      3'h3, 3'h4: return (c > 3'h2) ? 3'h2 : c;
      default: return c;
    endcase
  endfunction
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got_v);
    cmp_count++;
    if (got_v !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got_v);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    end_sim;
  end
  initial begin
    reset = 1'b1;
    parallel_mode = 1'b0;
    gain_pins = 3'h0;
    power_down_pin = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    prev = 16'h0000;
    void'($urandom(32'h7666));
    host_u.tick(2);
    reset = 1'b0;
    host_u.tick(4);
    chk("reset outputs", exp_vec(3'h0, 3'h0, 3'h0, 1'b0), seen);
    $display("test reset done");
    // corners first, then random words sweeping every gain and route code
    for (int i = 0; i < 12; i++) begin
      w = (i < 4) ? CORNER[i] : 16'($urandom);
      if (i >= 4) begin
        w[2:0] = 3'(i - 4);
        w[8:6] = 3'(i);
        w[5:3] = host_comp(w[2:0], w[5:3]);
      end
      host_u.send_word(w, got);
      chk("serial out", prev, got);
      prev = w;
      host_u.tick(8);
      chk("decode", exp_vec(w[2:0], w[5] ? 3'h4 : w[5:3], w[8:6], w[9]), seen);
    end
    $display("test serial done");
    // reset in mid-run must drop the loaded word and the chained shifter
    reset = 1'b1;
    host_u.tick(2);
    reset = 1'b0;
    host_u.tick(4);
    chk("mid reset outputs", exp_vec(3'h0, 3'h0, 3'h0, 1'b0), seen);
    chk("mid reset serial out", 16'h0000, {15'h0000, serial_out});
    prev = 16'h0000;
    $display("test mid reset done");
    parallel_mode = 1'b1;
    for (int g = 0; g < 8; g++) begin
      gain_pins = 3'(g);
      power_down_pin = 1'($urandom);
      host_u.tick(8);
      chk("parallel", exp_vec(3'(g), par_comp(3'(g)), prev[8:6], power_down_pin), seen);
    end
    $display("test parallel done");
    end_sim;
  end
endmodule
